// File: hdl/adc_pkg.sv
// Purpose: shared constants and carriers for the converter and comparator control block
// Assumes: classic Wishbone slave with 32-bit data, byte addresses
// Notes:   register byte address is four times the register index
package adc_pkg;

    // bus carriers
    localparam int WB_ADDR_W = 8;

    typedef struct packed {
        logic                 cyc;
        logic                 stb;
        logic                 we;
        logic [WB_ADDR_W-1:0] adr;
        logic [31:0]          dat;
        logic [3:0]           sel;
    } wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_rsp_t;

    // register indices
    localparam logic [5:0] RESULT_LOW_IDX   = 6'h04;
    localparam logic [5:0] RESULT_HIGH_IDX  = 6'h05;
    localparam logic [5:0] CONV_CTRL_IDX    = 6'h06;
    localparam logic [5:0] CHAN_SEL_IDX     = 6'h07;
    localparam logic [5:0] COMP_CTRL_IDX    = 6'h08;
    localparam logic [5:0] SPECIAL_FUNC_IDX = 6'h09;

    // converter control fields
    localparam int CONV_ENABLE_BIT = 7;
    localparam int CONV_START_BIT  = 6;
    localparam int CONV_FREE_BIT   = 5;
    localparam int CONV_FLAG_BIT   = 4;
    localparam int CONV_IE_BIT     = 3;
    localparam int CONV_PS_LSB     = 0;

    // channel select fields
    localparam int CHAN_REF_LSB  = 6;
    localparam int CHAN_LEFT_BIT = 5;
    localparam int CHAN_MUX_LSB  = 0;

    // comparator control fields
    localparam int COMP_DISABLE_BIT = 7;
    localparam int COMP_BANDGAP_BIT = 6;
    localparam int COMP_OUT_BIT     = 5;
    localparam int COMP_FLAG_BIT    = 4;
    localparam int COMP_IE_BIT      = 3;
    localparam int COMP_ROUTE_BIT   = 2;
    localparam int COMP_MODE_LSB    = 0;

    // special function field
    localparam int SPECIAL_MUX_EN_BIT = 3;

    // reset values
    localparam logic [7:0] REG_RESET = 8'h00;

    // comparator event modes
    localparam logic [1:0] CMP_MODE_TOGGLE  = 2'h0;
    localparam logic [1:0] CMP_MODE_FALLING = 2'h2;
    localparam logic [1:0] CMP_MODE_RISING  = 2'h3;

    // conversion timing in converter clock cycles
    localparam logic [4:0] NORMAL_CYCLES = 5'h0D;
    localparam logic [4:0] EXT_CYCLES    = 5'h19;
    localparam logic [4:0] SH_NORMAL     = 5'h01;   // plus half a cycle
    localparam logic [4:0] SH_EXT        = 5'h0D;   // plus half a cycle

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_CONV = 2'b11
    } conv_state_t;

endpackage : adc_pkg

// File: hdl/adc_sequencer_comparator_ctl.sv
// Purpose: converter sequencing, result registers and comparator digital side
// Assumes: one 25 MHz clock; analog inputs arrive asynchronously
// Notes:   registers reached over classic Wishbone, one byte per aligned word

module adc_sequencer_comparator_ctl (
    // clock and reset
    input  wire logic            clk,
    input  wire logic            reset,
    // register bus
    input  wire adc_pkg::wb_req_t wb_req,
    output adc_pkg::wb_rsp_t      wb_rsp,
    // cpu side
    input  wire logic            global_irq_enable,
    input  wire logic            conv_vector_taken,
    input  wire logic            comp_vector_taken,
    output logic                 conv_irq,
    output logic                 comp_irq,
    // analog front end
    input  wire logic            comparator_raw,
    input  wire logic [9:0]      sar_result_raw,
    output logic                 converter_power,
    output logic                 sample_hold,
    output logic [4:0]           channel_applied,
    output logic [1:0]           reference_applied,
    output logic [3:0]           neg_input_sel,
    output logic                 comparator_power_off,
    output logic                 bandgap_select,
    // timer capture front end
    output logic                 capture_input
);
    import adc_pkg::*;

    // register state
    logic [7:0]  comp_q;
    logic [7:0]  chan_q;
    logic [7:0]  conv_q;
    logic        mux_enable_q;
    logic [9:0]  result_q;
    logic        lock_q;
    logic        start_q;
    logic        conv_flag_q;
    logic        comp_flag_q;
    logic        ack_q;
    logic [31:0] rdat_q;

    // sequencer state
    conv_state_t state_q;
    logic [4:0]  cyc_cnt_q;
    logic        ext_q;
    logic        init_pend_q;
    logic [6:0]  pre_cnt_q;

    // synchronisers
    logic        cmp_meta_q;
    logic        cmp_sync_q;
    logic        cmp_prev_q;
    logic [9:0]  sar_meta_q;
    logic [9:0]  sar_sync_q;

    // output registers
    logic        conv_irq_q;
    logic        comp_irq_q;
    logic        sample_hold_q;
    logic [4:0]  channel_applied_q;
    logic [1:0]  reference_applied_q;
    logic [3:0]  neg_sel_q;
    logic        capture_q;

    function automatic logic [6:0] divisor_m1(input logic [2:0] code);
        if (code < 3'h2) begin
            return 7'h01;
        end
        return 7'((8'h01 << code) - 8'h01);
    endfunction : divisor_m1

    function automatic logic [15:0] aligned(input logic [9:0] r, input logic left);
        if (left) begin
            return {r, 6'h00};
        end
        return {6'h00, r};
    endfunction : aligned

    // bus decode
    logic       req;
    logic       wr;
    logic       rd;
    logic [5:0] idx;
    assign req = wb_req.cyc & wb_req.stb & ~ack_q;
    assign wr  = req & wb_req.we & wb_req.sel[0];
    assign rd  = req & ~wb_req.we;
    assign idx = wb_req.adr[WB_ADDR_W-1:2];

    logic wr_conv;
    logic wr_chan;
    logic wr_comp;
    logic wr_special;
    assign wr_conv    = wr && idx == CONV_CTRL_IDX;
    assign wr_chan    = wr && idx == CHAN_SEL_IDX;
    assign wr_comp    = wr && idx == COMP_CTRL_IDX;
    assign wr_special = wr && idx == SPECIAL_FUNC_IDX;

    logic enable;
    logic free_run;
    assign enable   = conv_q[CONV_ENABLE_BIT];
    assign free_run = conv_q[CONV_FREE_BIT];

    // prescaler ticks: rise at wrap, fall at half period
    logic [6:0] div_m1;
    logic       rise_tick;
    logic       fall_tick;
    assign div_m1    = divisor_m1(conv_q[CONV_PS_LSB +: 3]);
    assign rise_tick = enable && pre_cnt_q == div_m1;
    assign fall_tick = enable && pre_cnt_q == (div_m1 >> 1);

    logic [4:0] len_m1;
    logic [4:0] sh_at;
    logic       done;
    assign len_m1 = ext_q ? EXT_CYCLES - 5'h01 : NORMAL_CYCLES - 5'h01;
    assign sh_at  = ext_q ? SH_EXT : SH_NORMAL;
    assign done   = state_q == ST_CONV && rise_tick && cyc_cnt_q == len_m1;

    // comparator event select
    logic cmp_rise;
    logic cmp_fall;
    logic cmp_event;
    assign cmp_rise = cmp_sync_q & ~cmp_prev_q;
    assign cmp_fall = ~cmp_sync_q & cmp_prev_q;
    always_comb begin
        unique case (comp_q[COMP_MODE_LSB +: 2])
            CMP_MODE_TOGGLE:  cmp_event = cmp_rise | cmp_fall;
            CMP_MODE_FALLING: cmp_event = cmp_fall;
            CMP_MODE_RISING:  cmp_event = cmp_rise;
            default:          cmp_event = 1'b0;
        endcase
    end

    // synchronisers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cmp_meta_q <= 1'b0;
            cmp_sync_q <= 1'b0;
            cmp_prev_q <= 1'b0;
            sar_meta_q <= 10'h000;
            sar_sync_q <= 10'h000;
        end else begin
            cmp_meta_q <= comparator_raw;
            cmp_sync_q <= cmp_meta_q;
            cmp_prev_q <= cmp_sync_q;
            sar_meta_q <= sar_result_raw;
            sar_sync_q <= sar_meta_q;
        end
    end

    // software-written control bits
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            comp_q       <= REG_RESET;
            chan_q       <= REG_RESET;
            conv_q       <= REG_RESET;
            mux_enable_q <= 1'b0;
        end else begin
            if (wr_comp) begin
                comp_q <= wb_req.dat[7:0];
            end
            if (wr_chan) begin
                chan_q <= wb_req.dat[7:0];
            end
            if (wr_conv) begin
                conv_q <= wb_req.dat[7:0];
            end
            if (wr_special) begin
                mux_enable_q <= wb_req.dat[SPECIAL_MUX_EN_BIT];
            end
        end
    end

    // start bit: set by writing one with enable, cleared on single-mode completion or abort
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            start_q <= 1'b0;
        end else if (wr_conv && wb_req.dat[CONV_START_BIT] && wb_req.dat[CONV_ENABLE_BIT]) begin
            start_q <= 1'b1;
        end else if (!enable) begin
            start_q <= 1'b0;
        end else if (done && !free_run) begin
            start_q <= 1'b0;
        end
    end

    // prescaler, held at zero while the converter is off
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pre_cnt_q <= 7'h00;
        end else if (!enable || pre_cnt_q >= div_m1) begin
            pre_cnt_q <= 7'h00;
        end else begin
            pre_cnt_q <= pre_cnt_q + 7'h01;
        end
    end

    // conversion sequencer
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q             <= ST_IDLE;
            cyc_cnt_q           <= 5'h00;
            ext_q               <= 1'b0;
            init_pend_q         <= 1'b1;
            channel_applied_q   <= 5'h00;
            reference_applied_q <= 2'h0;
        end else if (!enable) begin
            state_q     <= ST_IDLE;
            cyc_cnt_q   <= 5'h00;
            ext_q       <= 1'b0;
            init_pend_q <= 1'b1;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (start_q) begin
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (rise_tick) begin
                        state_q             <= ST_CONV;
                        cyc_cnt_q           <= 5'h00;
                        ext_q               <= init_pend_q;
                        init_pend_q         <= 1'b0;
                        channel_applied_q   <= chan_q[CHAN_MUX_LSB +: 5];
                        reference_applied_q <= chan_q[CHAN_REF_LSB +: 2];
                    end
                end
                ST_CONV: begin
                    if (done) begin
                        cyc_cnt_q <= 5'h00;
                        ext_q     <= 1'b0;
                        if (free_run) begin
                            channel_applied_q   <= chan_q[CHAN_MUX_LSB +: 5];
                            reference_applied_q <= chan_q[CHAN_REF_LSB +: 2];
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end else if (rise_tick) begin
                        cyc_cnt_q <= cyc_cnt_q + 5'h01;
                    end
                end
            endcase
        end
    end

    // sample and hold strobe on the half-cycle falling edge
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sample_hold_q <= 1'b0;
        end else begin
            sample_hold_q <= state_q == ST_CONV && fall_tick && cyc_cnt_q == sh_at;
        end
    end

    // result register and read lock
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            result_q <= 10'h000;
        end else if (done && !lock_q) begin
            result_q <= sar_sync_q;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            lock_q <= 1'b0;
        end else if (rd && idx == RESULT_LOW_IDX) begin
            lock_q <= 1'b1;
        end else if (rd && idx == RESULT_HIGH_IDX) begin
            lock_q <= 1'b0;
        end
    end

    // flags: a hardware set beats a software clear in the same cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            conv_flag_q <= 1'b0;
        end else if (done) begin
            conv_flag_q <= 1'b1;
        end else if (conv_vector_taken || (wr_conv && wb_req.dat[CONV_FLAG_BIT])) begin
            conv_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            comp_flag_q <= 1'b0;
        end else if (cmp_event) begin
            comp_flag_q <= 1'b1;
        end else if (comp_vector_taken || (wr_comp && wb_req.dat[COMP_FLAG_BIT])) begin
            comp_flag_q <= 1'b0;
        end
    end

    // interrupt requests and comparator routing
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            conv_irq_q <= 1'b0;
            comp_irq_q <= 1'b0;
            capture_q  <= 1'b0;
            neg_sel_q  <= 4'h0;
        end else begin
            conv_irq_q <= conv_flag_q & conv_q[CONV_IE_BIT] & global_irq_enable;
            comp_irq_q <= comp_flag_q & comp_q[COMP_IE_BIT] & global_irq_enable;
            capture_q  <= comp_q[COMP_ROUTE_BIT] & cmp_sync_q;
            // msb set means a converter pin replaces the dedicated negative pin
            if (mux_enable_q && !enable) begin
                neg_sel_q <= {1'b1, chan_q[CHAN_MUX_LSB +: 3]};
            end else begin
                neg_sel_q <= 4'h0;
            end
        end
    end

    // bus answer, one wait state
    logic [15:0] view;
    assign view = aligned(result_q, chan_q[CHAN_LEFT_BIT]);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req;
            if (rd) begin
                unique case (idx)
                    RESULT_LOW_IDX:   rdat_q <= {24'h000000, view[7:0]};
                    RESULT_HIGH_IDX:  rdat_q <= {24'h000000, view[15:8]};
                    CONV_CTRL_IDX:    rdat_q <= {24'h000000, conv_q[7], start_q,
                                                 conv_q[5], conv_flag_q, conv_q[3:0]};
                    CHAN_SEL_IDX:     rdat_q <= {24'h000000, chan_q};
                    COMP_CTRL_IDX:    rdat_q <= {24'h000000, comp_q[7:6], cmp_sync_q,
                                                 comp_flag_q, comp_q[3:0]};
                    SPECIAL_FUNC_IDX: rdat_q <= {24'h000000, 4'h0, mux_enable_q, 3'h0};
                    default:          rdat_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign wb_rsp.ack           = ack_q;
    assign wb_rsp.dat           = rdat_q;
    assign conv_irq             = conv_irq_q;
    assign comp_irq             = comp_irq_q;
    assign converter_power      = conv_q[CONV_ENABLE_BIT];
    assign sample_hold          = sample_hold_q;
    assign channel_applied      = channel_applied_q;
    assign reference_applied    = reference_applied_q;
    assign neg_input_sel        = neg_sel_q;
    assign comparator_power_off = comp_q[COMP_DISABLE_BIT];
    assign bandgap_select       = comp_q[COMP_BANDGAP_BIT];
    assign capture_input        = capture_q;

endmodule : adc_sequencer_comparator_ctl

// File: sim/adc_ctl_monitor.sv
// Purpose: port-level checks for the converter and comparator control block
// Assumes: single clock domain, prescaler never below two clk per converter cycle
// Notes:   vector check only while converter is off, as no completion can race it
module adc_ctl_monitor (
    // clock and reset
    input wire logic             clk,
    input wire logic             reset,
    // register bus
    input wire adc_pkg::wb_req_t wb_req,
    input wire adc_pkg::wb_rsp_t wb_rsp,
    // cpu side
    input wire logic             global_irq_enable,
    input wire logic             conv_vector_taken,
    input wire logic             conv_irq,
    input wire logic             comp_irq,
    // analog front end
    input wire logic             converter_power,
    input wire logic             sample_hold,
    input wire logic [4:0]       channel_applied,
    input wire logic [3:0]       neg_input_sel
);
    import adc_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    bus_answer_a: assert property ((wb_req.cyc && wb_req.stb && !wb_rsp.ack) |=> wb_rsp.ack)
        else $error("bus request not answered after one wait state");
    ack_pulse_a: assert property (wb_rsp.ack |=> !wb_rsp.ack)
        else $error("bus ack longer than one cycle");
    read_upper_a: assert property (wb_rsp.ack |-> (wb_rsp.dat[31:8] == 24'h000000))
        else $error("read data upper bits not zero");
    conv_gate_a: assert property (!global_irq_enable |=> !conv_irq)
        else $error("conversion irq without global enable");
    comp_gate_a: assert property (!global_irq_enable |=> !comp_irq)
        else $error("comparator irq without global enable");
    neg_pin_a: assert property ((converter_power && $past(converter_power)) |->
        (neg_input_sel == 4'h0))
        else $error("negative input muxed while converter on");
    idle_hold_a: assert property ((!converter_power && !$past(converter_power)) |->
        !sample_hold)
        else $error("sample strobe while converter off");
    hold_gap_a: assert property (sample_hold |=> !sample_hold [*8])
        else $error("sample strobes too close together");
    ext_first_a: assert property ($rose(converter_power) |-> !sample_hold [*8])
        else $error("early sample strobe after enable");
    chan_hold_a: assert property (sample_hold |-> $stable(channel_applied))
        else $error("channel changed at sample instant");
    vec_clear_a: assert property ((conv_vector_taken && !converter_power) |->
        ##2 !conv_irq)
        else $error("vector did not clear conversion irq");
endmodule : adc_ctl_monitor

bind adc_sequencer_comparator_ctl adc_ctl_monitor mon (
    .clk(clk), .reset(reset), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .global_irq_enable(global_irq_enable), .conv_vector_taken(conv_vector_taken),
    .conv_irq(conv_irq), .comp_irq(comp_irq), .converter_power(converter_power),
    .sample_hold(sample_hold), .channel_applied(channel_applied),
    .neg_input_sel(neg_input_sel)
);

// File: sim/adc_sequencer_comparator_ctl_tb.sv
// Purpose: register-level test of converter sequencing and comparator logic
// Assumes: prescaler code 1 except in the divide-by-four check, so one converter cycle is two clk
// Notes:   durations judged with polling slack of a few clk
module adc_sequencer_comparator_ctl_tb;
    import adc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic             clk = 1'b0;
    logic             reset = 1'b1;
    wb_req_t          wb_req = '0;
    wb_rsp_t          wb_rsp;
    logic             glob = 1'b0;
    logic             conv_vec = 1'b0;
    logic             comp_vec = 1'b0;
    logic             cmp_raw = 1'b0;
    logic [9:0]       sar = 10'h000;
    logic             conv_irq, comp_irq, power, hold, cap;
    logic [4:0]       chan;
    logic [3:0]       neg;
    logic [1:0]       refs;
    logic             cpd, bg;
    logic [7:0]       r;
    int               err_total = 0;
    int               checks = 0;
    int               n;

    always #20 clk = ~clk;

    adc_sequencer_comparator_ctl uut (
        .clk(clk), .reset(reset), .wb_req(wb_req), .wb_rsp(wb_rsp),
        .global_irq_enable(glob), .conv_vector_taken(conv_vec),
        .comp_vector_taken(comp_vec), .conv_irq(conv_irq), .comp_irq(comp_irq),
        .comparator_raw(cmp_raw), .sar_result_raw(sar), .converter_power(power),
        .sample_hold(hold), .channel_applied(chan), .reference_applied(refs),
        .neg_input_sel(neg), .comparator_power_off(cpd), .bandgap_select(bg),
        .capture_input(cap)
    );

    task automatic end_of_test;
        if (err_total == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp, input string m);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s got %b expected %b", $time, m, got, exp);
        end
    endtask : chk1

    task automatic bus(input logic [5:0] idx, input logic we, input logic [7:0] wd,
                       output logic [7:0] rd);
        int k;
        k = 0;
        wb_req.cyc <= 1'b1;
        wb_req.stb <= 1'b1;
        wb_req.we  <= we;
        wb_req.adr <= {idx, 2'b00};
        wb_req.dat <= {24'h000000, wd};
        wb_req.sel <= 4'hF;
        do begin
            @(posedge clk);
            k++;
        end while (wb_rsp.ack !== 1'b1);
        chk1(k == 2, 1'b1, "bus answer");
        rd = wb_rsp.dat[7:0];
        wb_req <= '0;
        @(posedge clk);
    endtask : bus

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [7:0] x;
        bus(idx, 1'b1, d, x);
    endtask : wr

    task automatic rd(input logic [5:0] idx, output logic [7:0] d);
        bus(idx, 1'b0, 8'h00, d);
    endtask : rd

    // polls the start bit; returns elapsed clk
    task automatic wait_done(output int cyc);
        time t0;
        logic [7:0] s;
        t0 = $time;
        do begin
            rd(CONV_CTRL_IDX, s);
        end while (s[CONV_START_BIT] !== 1'b0 && ($time - t0) < 8000);
        cyc = int'(($time - t0) / 40);
    endtask : wait_done

    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rd(CONV_CTRL_IDX, r);
        chk8(r, REG_RESET, "conv ctrl reset");
        rd(CHAN_SEL_IDX, r);
        chk8(r, REG_RESET, "channel reset");
        rd(COMP_CTRL_IDX, r);
        chk8(r & 8'hDF, REG_RESET, "comp ctrl reset");
        wr(6'h3F, 8'hFF);
        rd(6'h3F, r);
        chk8(r, 8'h00, "unmapped read");
        // comparator negative input mux
        wr(SPECIAL_FUNC_IDX, 8'h08);
        wr(CHAN_SEL_IDX, 8'h05);
        repeat (2) @(posedge clk);
        chk8({4'h0, neg}, 8'h0D, "neg mux pin 5");
        // first conversion is extended
        sar <= 10'h2A5;
        // fast converter clock: reduced resolution accepted for run time
        wr(CONV_CTRL_IDX, 8'hC1);
        rd(CONV_CTRL_IDX, r);
        chk1(r[CONV_START_BIT], 1'b1, "start reads busy");
        chk8({3'h0, chan}, 8'h05, "channel applied");
        chk8({4'h0, neg}, 8'h00, "neg pin while enabled");
        wait_done(n);
        chk1(n inside {[45:56]}, 1'b1, "extended length");
        rd(CONV_CTRL_IDX, r);
        chk1(r[CONV_FLAG_BIT], 1'b1, "done flag");
        rd(RESULT_LOW_IDX, r);
        chk8(r, 8'hA5, "right low");
        rd(RESULT_HIGH_IDX, r);
        chk8(r, 8'h02, "right high");
        wr(CHAN_SEL_IDX, 8'h25);
        rd(RESULT_LOW_IDX, r);
        chk8(r, 8'h40, "left low");
        rd(RESULT_HIGH_IDX, r);
        chk8(r, 8'hA9, "left high");
        wr(CONV_CTRL_IDX, 8'h91);
        rd(CONV_CTRL_IDX, r);
        chk1(r[CONV_FLAG_BIT], 1'b0, "flag write one clears");
        // locked completion keeps old result but flags
        rd(RESULT_LOW_IDX, r);
        sar <= 10'h15A;
        wr(CONV_CTRL_IDX, 8'hC1);
        wr(CHAN_SEL_IDX, 8'h66);
        chk8({3'h0, chan}, 8'h05, "old channel kept");
        wait_done(n);
        chk1(n inside {[21:32]}, 1'b1, "normal length");
        rd(CONV_CTRL_IDX, r);
        chk1(r[CONV_FLAG_BIT], 1'b1, "flag while locked");
        rd(RESULT_HIGH_IDX, r);
        chk8(r, 8'hA9, "locked high");
        wr(CONV_CTRL_IDX, 8'hD1);
        wait_done(n);
        chk8({3'h0, chan}, 8'h06, "new channel after completion");
        chk8({6'h00, refs}, 8'h01, "reference applied");
        rd(RESULT_LOW_IDX, r);
        chk8(r, 8'h80, "new low");
        rd(RESULT_HIGH_IDX, r);
        chk8(r, 8'h56, "new high");
        // prescaler code 2: converter cycle is four clk
        wr(CONV_CTRL_IDX, 8'hD2);
        wait_done(n);
        chk1(n inside {[53:64]}, 1'b1, "divide by four length");
        // free running keeps start high, disable aborts
        wr(CONV_CTRL_IDX, 8'hF1);
        repeat (80) @(posedge clk);
        rd(CONV_CTRL_IDX, r);
        chk8(r & 8'h70, 8'h70, "free running busy");
        wr(CONV_CTRL_IDX, 8'h09);
        rd(CONV_CTRL_IDX, r);
        chk1(r[CONV_START_BIT], 1'b0, "abort clears start");
        chk1(power, 1'b0, "power off");
        glob <= 1'b1;
        repeat (3) @(posedge clk);
        chk1(conv_irq, 1'b1, "conv irq");
        conv_vec <= 1'b1;
        @(posedge clk);
        conv_vec <= 1'b0;
        repeat (3) @(posedge clk);
        chk1(conv_irq, 1'b0, "vector clears conv irq");
        // comparator event modes, irq disabled while changing mode
        for (int m = 0; m < 4; m++) begin
            wr(COMP_CTRL_IDX, 8'h10 | 8'(m));
            cmp_raw <= 1'b1;
            repeat (6) @(posedge clk);
            rd(COMP_CTRL_IDX, r);
            chk1(r[COMP_FLAG_BIT], m == 0 || m == 3, "rise event");
            wr(COMP_CTRL_IDX, 8'h10 | 8'(m));
            cmp_raw <= 1'b0;
            repeat (6) @(posedge clk);
            rd(COMP_CTRL_IDX, r);
            chk1(r[COMP_FLAG_BIT], m == 0 || m == 2, "fall event");
        end
        wr(COMP_CTRL_IDX, 8'h13);
        wr(COMP_CTRL_IDX, 8'h0F);
        cmp_raw <= 1'b1;
        repeat (6) @(posedge clk);
        chk1(comp_irq, 1'b1, "comp irq");
        chk1(cap, 1'b1, "capture routed");
        glob <= 1'b0;
        repeat (2) @(posedge clk);
        chk1(comp_irq, 1'b0, "global gate");
        comp_vec <= 1'b1;
        @(posedge clk);
        comp_vec <= 1'b0;
        wr(COMP_CTRL_IDX, 8'h03);
        rd(COMP_CTRL_IDX, r);
        chk1(r[COMP_FLAG_BIT], 1'b0, "vector clears comp flag");
        repeat (3) @(posedge clk);
        chk1(cap, 1'b0, "capture unrouted");
        wr(COMP_CTRL_IDX, 8'hC3);
        chk8({6'h00, cpd, bg}, 8'h03, "comparator power and bandgap");
        end_of_test();
    end

    // watchdog well beyond the expected few hundred clk
    initial begin
        #800000;
        err_total++;
        end_of_test();
    end
endmodule : adc_sequencer_comparator_ctl_tb
